//--- core/dig_gate.sv
// debug-aware maskable interrupt gate
// assumes halt level and requests come from core-clock logic
`timescale 1ns/100ps

module dig_gate (
  // clock, reset, enable
  input wire logic core_clk,
  input wire logic rst,
  input wire logic clk_en,
  // debug controller
  input wire logic user_halted,
  // interrupt sources
  input wire logic [dig_pkg::N_SRC-1:0] src_req,
  input wire logic [dig_pkg::N_SRC-1:0] src_enable,
  input wire logic [dig_pkg::N_SRC*dig_pkg::LVL_W-1:0] src_level,
  // processor flags
  input wire logic cpu_int_enable,
  input wire logic [dig_pkg::LVL_W-1:0] cpu_ipl,
  // processor memory read port
  input wire logic mem_rd,
  input wire logic [dig_pkg::ADDR_W-1:0] mem_addr,
  output logic [dig_pkg::DATA_W-1:0] mem_rdata,
  output logic mem_rvalid,
  // stack pointer
  input wire logic isp_wr,
  input wire logic [dig_pkg::ADDR_W-1:0] isp_wdata,
  output logic [dig_pkg::ADDR_W-1:0] interrupt_stack_pointer,
  output logic [dig_pkg::ADDR_W-1:0] work_area_base,
  // interrupt request to core
  output logic irq_request,
  output logic [dig_pkg::NUM_W-1:0] irq_number,
  output logic [dig_pkg::LVL_W-1:0] irq_level,
  // status
  output logic [dig_pkg::N_SRC-1:0] pending_out,
  output logic irq_withheld,
  output logic [dig_pkg::CNT_W-1:0] withheld_cycles
);

  // ==========================================================
  // declarations
  dig_req_if req ();
  dig_pkg::dig_state_t state;
  dig_pkg::dig_state_t next_state;
  logic [dig_pkg::N_SRC-1:0] pending;
  logic [dig_pkg::N_SRC-1:0] clr_mask;
  logic ack_num;
  logic ack_lvl;
  logic ack_any;
  logic gate_open;
  logic eligible;
  logic next_request;
  logic [dig_pkg::NUM_W-1:0] win_number;

  // ==========================================================
  // picker
  assign req.pending = pending;
  assign req.enable = src_enable;
  assign req.levels = src_level;

  dig_pick u_pick (
    .req(req.pick)
  );

  assign win_number = dig_pkg::VECTOR_BASE +
                      dig_pkg::NUM_W'(req.win_index);

  // ==========================================================
  // acknowledge decode
  assign ack_num = mem_rd && (mem_addr == dig_pkg::ADDR_IRQ_NUM);
  assign ack_lvl = mem_rd && (mem_addr == dig_pkg::ADDR_IRQ_LVL);
  // any read of either address clears, even a stray one
  assign ack_any = ack_num || ack_lvl;

  always_comb begin
    clr_mask = '0;
    if (ack_any && req.win_valid) begin
      clr_mask[req.win_index] = 1'b1;
    end
  end

  // ==========================================================
  // halt tracking
  always_comb begin
    next_state = state;
    unique case (state)
      dig_pkg::DIG_RUN: begin
        if (user_halted) begin
          next_state = dig_pkg::DIG_HALTED;
        end
      end
      dig_pkg::DIG_HALTED: begin
        if (!user_halted) begin
          next_state = dig_pkg::DIG_RESUME;
        end
      end
      dig_pkg::DIG_RESUME: begin
        if (user_halted) begin
          next_state = dig_pkg::DIG_HALTED;
        end else begin
          next_state = dig_pkg::DIG_RUN;
        end
      end
      default: begin
        next_state = dig_pkg::DIG_RUN;
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      state <= dig_pkg::DIG_RUN;
    end else if (clk_en) begin
      state <= next_state;
    end
  end

  // ==========================================================
  // pending bits
  // set wins over clear; latching goes on while halted
  always_ff @(posedge core_clk) begin
    if (rst) begin
      pending <= '0;
    end else if (clk_en) begin
      pending <= (pending & ~clr_mask) | src_req;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      pending_out <= '0;
    end else if (clk_en) begin
      pending_out <= (pending & ~clr_mask) | src_req;
    end
  end

  // ==========================================================
  // acceptance gate
  // halt closes the gate for every source class
  assign gate_open = !user_halted && cpu_int_enable;
  assign eligible = req.win_valid && (req.win_level > cpu_ipl);
  // no latch of the refusal: held request goes out on resume
  assign next_request = eligible && gate_open && !ack_any;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      irq_request <= 1'b0;
    end else if (clk_en) begin
      irq_request <= next_request;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      irq_number <= '0;
      irq_level <= '0;
    end else if (clk_en) begin
      irq_number <= win_number;
      irq_level <= req.win_level;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      irq_withheld <= 1'b0;
    end else if (clk_en) begin
      irq_withheld <= eligible && user_halted;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      withheld_cycles <= '0;
    end else if (clk_en) begin
      if (next_state == dig_pkg::DIG_RESUME) begin
        withheld_cycles <= '0;
      end else if (eligible && user_halted &&
                   withheld_cycles != dig_pkg::CNT_MAX) begin
        withheld_cycles <= withheld_cycles + 16'h0001;
      end
    end
  end

  // ==========================================================
  // acknowledge data
  // address 0 gives number, address 1 gives level
  always_ff @(posedge core_clk) begin
    if (rst) begin
      mem_rdata <= '0;
      mem_rvalid <= 1'b0;
    end else if (clk_en) begin
      mem_rvalid <= ack_any;
      if (ack_num) begin
        mem_rdata <= win_number;
      end else if (ack_lvl) begin
        mem_rdata <= {{(dig_pkg::DATA_W-dig_pkg::LVL_W){1'b0}},
                      req.win_level};
      end else begin
        mem_rdata <= '0;
      end
    end
  end

  // ==========================================================
  // interrupt stack pointer
  always_ff @(posedge core_clk) begin
    if (rst) begin
      interrupt_stack_pointer <= dig_pkg::ISP_RESET;
    end else if (clk_en && isp_wr) begin
      interrupt_stack_pointer <= isp_wdata;
    end
  end

  // emulator work area sits just below the pointer
  always_ff @(posedge core_clk) begin
    if (rst) begin
      work_area_base <= dig_pkg::ISP_RESET -
                        dig_pkg::WORK_AREA_BYTES;
    end else if (clk_en) begin
      if (isp_wr) begin
        work_area_base <= isp_wdata - dig_pkg::WORK_AREA_BYTES;
      end else begin
        work_area_base <= interrupt_stack_pointer -
                          dig_pkg::WORK_AREA_BYTES;
      end
    end
  end

endmodule

//--- core/dig_pkg.sv
// package for the debug-aware interrupt gate
// assumes one core clock and synchronous active-high reset
package dig_pkg;

  // ==========================================================
  // sizes
  localparam int N_SRC = 8;
  localparam int IDX_W = 3;
  localparam int LVL_W = 3;
  localparam int NUM_W = 8;
  localparam int ADDR_W = 20;
  localparam int DATA_W = 8;
  localparam int CNT_W = 16;

  // ==========================================================
  // addresses and reset values
  localparam logic [ADDR_W-1:0] ADDR_IRQ_NUM = 20'h0_0000;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_LVL = 20'h0_0001;
  localparam logic [ADDR_W-1:0] ISP_RESET = 20'h0_0500;
  localparam logic [ADDR_W-1:0] WORK_AREA_BYTES = 20'h0_0008;
  localparam logic [NUM_W-1:0] VECTOR_BASE = 8'h00;
  localparam logic [CNT_W-1:0] CNT_MAX = 16'hFFFF;

  // ==========================================================
  // gate state
  typedef enum logic [1:0] {
    DIG_RUN = 2'b00,
    DIG_HALTED = 2'b01,
    DIG_RESUME = 2'b10
  } dig_state_t;

  // pick index of highest level, lowest index on ties
  function automatic logic is_better(
    input logic [LVL_W-1:0] cand,
    input logic [LVL_W-1:0] best,
    input logic have
  );
    is_better = !have || (cand > best);
  endfunction

endpackage

//--- core/dig_req_if.sv
// carrier between the gate and its priority picker
// assumes both ends sit in the same core clock domain
`timescale 1ns/100ps

interface dig_req_if;
  logic [dig_pkg::N_SRC-1:0] pending;
  logic [dig_pkg::N_SRC-1:0] enable;
  logic [dig_pkg::N_SRC*dig_pkg::LVL_W-1:0] levels;
  logic win_valid;
  logic [dig_pkg::IDX_W-1:0] win_index;
  logic [dig_pkg::LVL_W-1:0] win_level;

  modport ctl (
    output pending,
    output enable,
    output levels,
    input win_valid,
    input win_index,
    input win_level
  );

  modport pick (
    input pending,
    input enable,
    input levels,
    output win_valid,
    output win_index,
    output win_level
  );
endinterface

//--- core/dig_pick.sv
// priority picker over pending and enabled sources
// assumes combinational use inside the gate
`timescale 1ns/100ps

module dig_pick (
  // request set
  dig_req_if.pick req
);

  // ==========================================================
  // highest level wins, lowest index breaks ties
  always_comb begin
    logic have;
    logic [dig_pkg::IDX_W-1:0] idx;
    logic [dig_pkg::LVL_W-1:0] lvl;
    logic [dig_pkg::LVL_W-1:0] cand;
    have = 1'b0;
    idx = '0;
    lvl = '0;
    cand = '0;
    for (int i = 0; i < dig_pkg::N_SRC; i++) begin
      cand = req.levels[i*dig_pkg::LVL_W +: dig_pkg::LVL_W];
      if (req.pending[i] && req.enable[i] &&
          dig_pkg::is_better(cand, lvl, have)) begin
        have = 1'b1;
        idx = dig_pkg::IDX_W'(i);
        lvl = cand;
      end
    end
    req.win_valid = have;
    req.win_index = idx;
    req.win_level = lvl;
  end

endmodule

//--- verification/dig_gate_properties.sv
// checker for the debug-aware interrupt gate
// assumes it is bound onto dig_gate, one clock domain
`timescale 1ns/100ps

module dig_gate_properties (
  // clock, reset, enable
  input wire logic core_clk,
  input wire logic rst,
  input wire logic clk_en,
  // core and sources
  input wire logic user_halted,
  input wire logic cpu_int_enable,
  input wire logic [7:0] src_req,
  input wire logic mem_rd,
  input wire logic [19:0] mem_addr,
  // gate outputs
  input wire logic mem_rvalid,
  input wire logic irq_request,
  input wire logic irq_withheld,
  input wire logic [7:0] pending_out,
  input wire logic [19:0] interrupt_stack_pointer,
  input wire logic [19:0] work_area_base
);
  // ====================
  // properties
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst || !clk_en);
  wire rd_ack = mem_rd && mem_addr < 20'h0_0002;

  AST_HALT_BLOCK: assert property (user_halted |=> !irq_request)
    else $error("request raised while halted");
  AST_RESUME: assert property ($fell(user_halted) && irq_withheld &&
    cpu_int_enable && !rd_ack |=> irq_request)
    else $error("held request not taken on resume");
  AST_WITHHELD_QUIET: assert property (irq_withheld |-> !irq_request)
    else $error("withheld source still requested");
  AST_KEEP_LATCHING: assert property (src_req != 8'h00 |=>
    (pending_out & $past(src_req)) == $past(src_req))
    else $error("request not latched");
  AST_ACK_VALID: assert property (rd_ack |=> mem_rvalid)
    else $error("acknowledge read gave no data");
  AST_NO_STRAY_VALID: assert property (!rd_ack |=> !mem_rvalid)
    else $error("data valid without acknowledge read");
  AST_ACK_DROPS: assert property (rd_ack |=> !irq_request)
    else $error("request kept after acknowledge read");
  AST_ISP_RESET: assert property ($fell(rst) |->
    interrupt_stack_pointer == 20'h0_0500)
    else $error("stack pointer wrong after reset");
  AST_WORK_AREA: assert property (
    work_area_base == interrupt_stack_pointer - 20'h0_0008)
    else $error("work area base not pointer minus 8");

  cover property ($fell(user_halted) && irq_withheld);
  cover property (rd_ack && irq_request);
  cover property (src_req != 8'h00 && user_halted);
endmodule

bind dig_gate dig_gate_properties chk (.*);

//--- verification/dig_core_model.sv
// processor core and debug halt control facing the gate
// assumes the bench calls its tasks, inputs change at falling edge
`timescale 1ns/100ps

module dig_core_model (
  // clock
  input wire logic core_clk,
  // read port
  output logic mem_rd,
  output logic [19:0] mem_addr,
  input wire logic [7:0] mem_rdata,
  input wire logic mem_rvalid,
  // debug halt level
  output logic user_halted
);
  logic [19:0] rd_addr;
  logic [19:0] idle_addr = 20'h0_4000;

  // ====================
  // address wanders while no read is made
  always @(negedge core_clk) idle_addr <= idle_addr + 20'h0_0001;
  assign mem_addr = mem_rd ? rd_addr : idle_addr;

  initial begin
    mem_rd = 1'b0;
    rd_addr = 20'h0_0000;
    user_halted = 1'b0;
  end

  // halt level, held across edges
  task automatic set_halt(input logic h);
    @(negedge core_clk);
    user_halted = h;
  endtask

  // one strobe after a gap, data taken one cycle later
  task automatic read(input logic [19:0] a, input int gap,
                      output logic [7:0] d, output logic v);
    repeat (gap + 1) @(negedge core_clk);
    rd_addr = a;
    mem_rd = 1'b1;
    @(negedge core_clk);
    mem_rd = 1'b0;
    d = mem_rdata;
    v = mem_rvalid;
  endtask
endmodule

//--- verification/dig_gate_test.sv
// self-checking bench for the debug-aware interrupt gate
// assumes dig_gate and the core model are compiled before it
`timescale 1ns/100ps

module dig_gate_test;
  logic core_clk, rst, clk_en, user_halted, cpu_int_enable, v;
  logic mem_rd, mem_rvalid, isp_wr, irq_request, irq_withheld;
  logic [7:0] src_req, src_enable, mem_rdata, irq_number, pending_out;
  logic [7:0] d, pend;
  logic [23:0] src_level;
  logic [2:0] cpu_ipl, irq_level, lv;
  logic [19:0] mem_addr, isp_wdata, interrupt_stack_pointer, work_area_base;
  logic [15:0] withheld_cycles;
  int num_errors = 0, checks = 0, w, s;

  dig_gate dut (.*);
  dig_core_model core (.*);

  always #20 core_clk = ~core_clk;

  // ====================
  // helpers
  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  function automatic int best(input logic [7:0] p, input logic [23:0] l);
    best = -1;
    for (int i = 0; i < 8; i++) begin
      if (p[i] && (best < 0 || l[3*i+:3] > l[3*best+:3])) best = i;
    end
  endfunction

  task automatic end_sim;
    $display("checks %0d mismatches %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge core_clk);
    num_errors++;
    end_sim;
  end

  // ====================
  // main sequence
  initial begin
    core_clk = 0; rst = 1; clk_en = 1; src_req = 0; src_enable = 8'hFF;
    src_level = 0; cpu_int_enable = 1; cpu_ipl = 0; isp_wr = 0;
    isp_wdata = 0;
    void'($urandom(5));
    repeat (12) @(posedge core_clk);
    @(negedge core_clk) rst = 0;
    check("pointer", interrupt_stack_pointer, 20'h0_0500);
    check("work", work_area_base, 20'h0_04F8);
    // acknowledge reads in priority order, at least one extra on empty set
    for (int r = 0; r < 4; r++) begin
      @(negedge core_clk);
      for (int i = 0; i < 8; i++) src_level[3*i+:3] = 3'($urandom_range(7, 1));
      pend = r == 0 ? 8'hFF : 8'($urandom);
      src_req = pend;
      @(negedge core_clk);
      src_req = 8'h00;
      for (int k = 0; k < 9; k++) begin
        w = best(pend, src_level);
        core.read({19'h0_0000, k[0]}, k % 3, d, v);
        check("valid", v, 1'b1);
        check("data", d, w < 0 ? 0 : k[0] ? src_level[3*w+:3] : w);
        if (w >= 0) pend[w] = 1'b0;
        check("pending", pending_out, pend);
      end
    end
    $display("test acknowledge done");
    // request during halt held, taken on resume
    for (int r = 0; r < 3; r++) begin
      s = $urandom_range(7, 0);
      lv = 3'($urandom_range(7, 1));
      core.set_halt(1'b1);
      @(negedge core_clk);
      src_level[3*s+:3] = lv;
      src_req[s] = 1'b1;
      @(negedge core_clk);
      src_req = 8'h00;
      repeat (5) @(negedge core_clk);
      check("held", irq_request, 1'b0);
      check("withheld", irq_withheld, 1'b1);
      check("latched", pending_out, 8'h01 << s);
      check("count", withheld_cycles, 16'h0005);
      core.set_halt(1'b0);
      @(negedge core_clk);
      check("resume", irq_request, 1'b1);
      check("number", irq_number, s);
      check("level", irq_level, lv);
      check("count clear", withheld_cycles, 16'h0000);
      core.read(20'h0_0000, r, d, v);
      check("ack", d, s);
      check("cleared", pending_out, 8'h00);
    end
    $display("test halt done");
    // threshold, core enable and source enable gate the request
    s = $urandom_range(7, 0);
    lv = 3'($urandom_range(7, 1));
    @(negedge core_clk);
    src_level[3*s+:3] = lv;
    src_req[s] = 1'b1;
    cpu_ipl = lv;
    @(negedge core_clk);
    src_req = 8'h00;
    @(negedge core_clk);
    check("at ipl", irq_request, 1'b0);
    cpu_ipl = lv - 3'h1;
    @(negedge core_clk);
    check("above ipl", irq_request, 1'b1);
    cpu_int_enable = 0;
    @(negedge core_clk);
    check("int off", irq_request, 1'b0);
    cpu_int_enable = 1;
    src_enable[s] = 1'b0;
    @(negedge core_clk);
    check("src off", irq_request, 1'b0);
    core.read(20'h0_0000, 0, d, v);
    check("no winner", d, 8'h00);
    check("kept", pending_out, 8'h01 << s);
    src_enable = 8'hFF;
    cpu_ipl = 0;
    core.read(20'h0_0000, 0, d, v);
    check("taken", d, s);
    check("gone", pending_out, 8'h00);
    $display("test mask done");
    // stack pointer load keeps the work area below it
    @(negedge core_clk);
    isp_wdata = 20'h0_0400 + 20'($urandom_range(4095, 8));
    isp_wr = 1;
    @(negedge core_clk);
    isp_wr = 0;
    check("load", interrupt_stack_pointer, isp_wdata);
    check("margin", work_area_base, isp_wdata - 20'h0_0008);
    $display("test stack done");
    // clock enable low freezes every register
    @(negedge core_clk);
    clk_en = 0;
    src_req = 8'($urandom_range(255, 1));
    @(negedge core_clk);
    src_req = 8'h00;
    core.read(20'h0_0001, 0, d, v);
    check("frozen valid", v, 1'b0);
    check("frozen pending", pending_out, 8'h00);
    clk_en = 1;
    $display("test freeze done");
    // reset in mid-run brings the pointer back
    @(negedge core_clk);
    rst = 1;
    @(negedge core_clk);
    rst = 0;
    check("pointer again", interrupt_stack_pointer, 20'h0_0500);
    check("work again", work_area_base, 20'h0_04F8);
    $display("test reset done");
    end_sim;
  end
endmodule
